// ===== graphic_lcd_host_command_port_bench.sv
/*
  Bench of the display host command port against a reference model.
  Assumes lcp_host drives the bus pins; straps driven by the bench.
*/
module graphic_lcd_host_command_port_bench
  import lcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, ctrl_reset_n, ce_n, rd_n, wr_n, cd, data_oe;
  logic        col_strap_a, col_strap_b, font_strap_a, font_strap_b;
  logic        glyph_source_sel, blink_phase;
  logic [7:0]  data_in, data_out, text_col_count, graphic_col_count;
  logic [15:0] addr_ptr, text_base_addr, graphic_base_addr;
  logic [6:0]  cursor_col, hw_col_count;
  logic [4:0]  cursor_row, glyph_offset;
  logic [3:0]  display_enable, cursor_height, font_width;
  logic [2:0]  merge_mode;
  logic [7:0]  d1, d2, st, v;
  logic [31:0] seed = 32'h5bcb92eb;
  int          num_errors, num_checks, ptr;
  byte unsigned ram [int];
  int          cols [4] = '{80, 64, 40, 32};
  int          fonts [4] = '{8, 7, 6, 5};
  logic [2:0]  modes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic [2:0]  seq [8] = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h1, 3'h3, 3'h5, 3'h7};

  lcp_cmd_port #(.BLINK_CYC(8)) uut (
    .clk(clk), .rst(rst), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .cd(cd),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ctrl_reset_n(ctrl_reset_n), .col_strap_a(col_strap_a),
    .col_strap_b(col_strap_b), .font_strap_a(font_strap_a),
    .font_strap_b(font_strap_b), .addr_ptr(addr_ptr),
    .cursor_col(cursor_col), .cursor_row(cursor_row),
    .glyph_offset(glyph_offset), .text_base_addr(text_base_addr),
    .text_col_count(text_col_count),
    .graphic_base_addr(graphic_base_addr),
    .graphic_col_count(graphic_col_count),
    .glyph_source_sel(glyph_source_sel), .merge_mode(merge_mode),
    .display_enable(display_enable), .cursor_height(cursor_height),
    .blink_phase(blink_phase), .hw_col_count(hw_col_count),
    .font_width(font_width));

  lcp_host host (.clk(clk), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
    .cd(cd), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] rnd8();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed[7:0];
  endfunction

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic setp(input int a);
    host.send(OP_ADDR_SET, 2, a[7:0], a[15:8]);
    ptr = a;
  endtask

  // Single byte access with the model's pointer step
  task automatic acc(input logic [2:0] n, input logic [7:0] d);
    host.send({5'h18, n}, n[0] ? 0 : 1, d);
    if (n[0]) begin
      host.wait_st(8'h02, st);
      host.xfer(1'b0, 1'b0, 8'h00, v);
      chk("read", v, ram[ptr]);
    end else begin
      ram[ptr] = d;
    end
    if (!n[2]) ptr = n[1] ? ptr - 1 : ptr + 1;
    chk("pointer", addr_ptr, ptr[15:0]);
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    {rst, ctrl_reset_n} = 2'b11;
    {col_strap_b, col_strap_a, font_strap_b, font_strap_a} = 4'hf;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk("enables", display_enable, 4'h0);
    host.wait_st(8'h00, st);
    chk("status", st & 8'hef, 8'ha3);
    for (int i = 0; i < 4; i++) begin
      {col_strap_b, col_strap_a} = i[1:0];
      {font_strap_b, font_strap_a} = ~i[1:0];
      repeat (8) @(negedge clk);
      chk("columns", hw_col_count, 16'(cols[i]));
      chk("font", font_width, 16'(fonts[3 - i]));
    end
    d1 = rnd8();
    d2 = rnd8();
    host.send(OP_CURSOR_SET, 2, d1, d2);
    chk("cursor col", cursor_col, d1[6:0]);
    chk("cursor row", cursor_row, d2[4:0]);
    host.send(OP_OFFSET_SET, 2, d1, 8'h00);
    chk("offset", glyph_offset, d1[4:0]);
    host.send(OP_ADDR_SET, 2, d1, d2);
    chk("address", addr_ptr, {d2, d1});
    for (int n = 0; n < 4; n++) begin
      d1 = rnd8();
      d2 = n[0] ? 8'h00 : rnd8();
      host.send({6'h10, n[1:0]}, 2, d1, d2);
      case (n)
        0: chk("text base", text_base_addr, {d2, d1});
        1: chk("text cols", text_col_count, d1);
        2: chk("gfx base", graphic_base_addr, {d2, d1});
        default: chk("gfx cols", graphic_col_count, d1);
      endcase
    end
    foreach (modes[k]) begin
      d1 = rnd8();
      host.send({4'h8, d1[0], modes[k]});
      chk("glyph source", glyph_source_sel, d1[0]);
      chk("merge", merge_mode, modes[k]);
    end
    d1 = rnd8();
    host.send({4'h9, d1[3:0]});
    chk("display", display_enable, d1[3:0]);
    host.send(8'h91);
    d1[0] = blink_phase;
    repeat (8) @(negedge clk);
    chk("blink toggle", blink_phase, !d1[0]);
    host.send(8'h9e);
    chk("display", display_enable, 4'he);
    chk("blink", blink_phase, 1'b1);
    ctrl_reset_n = 1'b0;
    repeat (6) @(negedge clk);
    host.wait_st(8'h00, st);
    chk("operable", st[5], 1'b0);
    ctrl_reset_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("enables", display_enable, 4'h0);
    for (int n = 0; n < 8; n++) begin
      host.send({5'h14, n[2:0]});
      chk("cursor height", cursor_height, 16'(n + 1));
    end
    setp('h100);
    foreach (seq[k]) acc(seq[k], rnd8());
    for (int k = 0; k < 4; k++) begin
      setp('h300 + k);
      acc(3'h4, rnd8());
      d1 = rnd8();
      d1[3] = k[0];
      host.send({4'hf, d1[3:0]});
      ram[ptr][d1[2:0]] = d1[3];
      acc(3'h5, 8'h00);
    end
    setp('h400);
    host.send(8'hb0);
    for (int k = 0; k < 5; k++) begin
      d1 = rnd8();
      host.wait_st(8'h08, st);
      host.xfer(1'b1, k == 4, k == 4 ? OP_ADDR_SET : d1, st);
      if (k < 4) ram[ptr++] = d1;
    end
    host.send(8'hb2, 0, 8'h00, 8'h00, 8'h08);
    chk("auto write", addr_ptr, ptr[15:0]);
    setp('h400);
    host.send(8'hb1);
    for (int k = 0; k < 4; k++) begin
      host.wait_st(8'h04, st);
      host.xfer(1'b0, 1'b0, 8'h00, v);
      chk("auto read", v, ram[ptr++]);
    end
    host.send(8'hb3, 0, 8'h00, 8'h00, 8'h04);
    chk("auto read", addr_ptr, ptr[15:0]);
    host.send(8'h80);
    host.send(8'h42, 2, 8'h00, 8'h02);
    host.send(8'h43, 2, 8'h1e, 8'h00);
    for (int k = 0; k < 4; k++) begin
      setp(k[1] ? 'h1000 : 'h400);
      host.send(k[0] ? OP_COPY : OP_PEEK);
      host.wait_st(8'h01, st);
      chk("range flag", st[6], k[1]);
      if (k == 0) begin
        host.wait_st(8'h02, st);
        host.xfer(1'b0, 1'b0, 8'h00, v);
        chk("peek", v, ram['h400]);
      end
    end
    chk("host timeouts", 16'(host.timeouts), 16'h0000);
    stop_test();
  end
endmodule // graphic_lcd_host_command_port_bench

// ===== lcp_cmd_port.sv
/*
  Host command port of a graphic display controller: status poll, data
  stack, command decode, display RAM access, auto modes, peek and copy.
  Assumes host pins are asynchronous and the host polls status first.
*/
// What this block does
// - Status byte driven on read with select high
// - Bit0 command ready, bit1 data ready
// - Bits 2 and 3 flag auto read/write
// - Bit5 operable, bit7 shows blink phase
// - Bit6 set on peek/copy outside graphics
// - Pointer command loads cursor, offset or address
// - Cursor column seven bits, row five bits
// - Offset takes low five bits of first
// - Address pointer low byte then high
// - Layout command sets bases and column counts
// - Bases locate text and graphic home
// - Column counts from first byte, strap independent
// - Mode command: glyph source and merge
// - Display command enables graphic, text, cursor, blink
// - Cursor height is field plus one
// - Auto write, auto read, exit; pointer increments
// - Single access read/write with pointer step
// - Peek puts displayed byte on data stack
// - Line copy into graphics, refused outside
// - Bit command sets or clears one bit
// - Straps give column count and font width
// - Select high write is command, else data
// - Reset clears all display enables
// - Auto mode: bytes are data, only exit
module lcp_cmd_port
  import lcp_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int GFX_LINES = 64,
  parameter bit DUAL_SCREEN = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       cd,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       ctrl_reset_n,
  input  wire logic       col_strap_a,
  input  wire logic       col_strap_b,
  input  wire logic       font_strap_a,
  input  wire logic       font_strap_b,
  output logic     [15:0] addr_ptr,
  output logic      [6:0] cursor_col,
  output logic      [4:0] cursor_row,
  output logic      [4:0] glyph_offset,
  output logic     [15:0] text_base_addr,
  output logic      [7:0] text_col_count,
  output logic     [15:0] graphic_base_addr,
  output logic      [7:0] graphic_col_count,
  output logic            glyph_source_sel,
  output logic      [2:0] merge_mode,
  output logic      [3:0] display_enable,
  output logic      [3:0] cursor_height,
  output logic            blink_phase,
  output logic      [6:0] hw_col_count,
  output logic      [3:0] font_width
);
  typedef struct packed {
    logic              wr_prev;
    logic              rd_prev;
    logic              oe;
    logic [7:0]        dout;
    logic [7:0]        d1;
    logic [7:0]        d2;
    logic [1:0]        dcnt;
    logic [15:0]       addr_ptr;
    logic [6:0]        cursor_col;
    logic [4:0]        cursor_row;
    logic [4:0]        glyph_offset;
    logic [15:0]       text_base_addr;
    logic [7:0]        text_col_count;
    logic [15:0]       graphic_base_addr;
    logic [7:0]        graphic_col_count;
    logic              glyph_source_sel;
    logic [2:0]        merge_mode;
    logic [3:0]        disp_en;
    logic [2:0]        cursor_lines;
    lcp_auto_t         auto_mode;
    lcp_fsm_t          fsm;
    logic [7:0]        copy_idx;
    logic [BUSY_W-1:0] busy;
    logic              err;
    logic [31:0]       blink_cnt;
    logic              blink;
    logic [7:0]        stack;
    logic [6:0]        hw_cols;
    logic [3:0]        font_w;
  } lcp_state_t;

  lcp_state_t r;
  lcp_state_t next_r;
  logic [7:0] ram [RAM_BYTES];

  logic [15:0] sync_q;
  logic        cd_s, wr_s, rd_s, rstn_s;
  logic        col_b, col_a, font_b, font_a;
  logic [7:0]  wbyte;
  logic        wr_trail, rd_lead, rd_trail, ready, in_gfx;
  logic [16:0] gfx_end;
  logic [7:0]  status, ram_q, last_data;
  logic [15:0] rd_addr, ptr_inc, ptr_dec;
  logic        ram_we;
  logic [ADDR_W-1:0] ram_wa;
  logic [7:0]  ram_wd;

  initial begin
    if (BLINK_CYC < 2) $error("lcp_cmd_port: BLINK_CYC too small");
    if (GFX_LINES < 1) $error("lcp_cmd_port: GFX_LINES must be positive");
  end

  lcp_sync3 #(.W(16), .INIT(16'h0010)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({cd, data_in, ~ce_n & ~wr_n, ~ce_n & ~rd_n, ctrl_reset_n,
           col_strap_b, col_strap_a, font_strap_b, font_strap_a}),
    .q   (sync_q)
  );

  assign {cd_s, wbyte, wr_s, rd_s, rstn_s, col_b, col_a, font_b, font_a} =
    sync_q;

  assign wr_trail  = r.wr_prev & ~wr_s;
  assign rd_lead   = rd_s & ~r.rd_prev;
  assign rd_trail  = r.rd_prev & ~rd_s;
  assign ready     = (r.busy == '0) && (r.fsm == FSM_IDLE);
  assign gfx_end   = {1'b0, r.graphic_base_addr}
                   + 17'(r.graphic_col_count * GFX_LINES);
  assign in_gfx    = (r.addr_ptr >= r.graphic_base_addr)
                   && ({1'b0, r.addr_ptr} < gfx_end);
  assign rd_addr   = (r.fsm == FSM_COPY) ? r.addr_ptr + 16'(r.copy_idx)
                                         : r.addr_ptr;
  assign ram_q     = ram[rd_addr[ADDR_W-1:0]];
  assign ptr_inc   = r.addr_ptr + 16'h0001;
  assign ptr_dec   = r.addr_ptr - 16'h0001;
  assign last_data = (r.dcnt == 2'h2) ? r.d2 : r.d1;

  always_comb begin
    status              = 8'h00;
    status[ST_CMD_OK]   = ready && (r.auto_mode == AUTO_OFF);
    status[ST_DATA_OK]  = ready && (r.auto_mode == AUTO_OFF);
    status[ST_AUTO_RD]  = ready && (r.auto_mode == AUTO_RD);
    status[ST_AUTO_WR]  = ready && (r.auto_mode == AUTO_WR);
    status[ST_OPERABLE] = rstn_s;
    status[ST_ERR]      = r.err;
    status[ST_BLINK]    = r.blink;
  end

  always_comb begin
    next_r         = r;
    ram_we         = 1'b0;
    ram_wa         = r.addr_ptr[ADDR_W-1:0];
    ram_wd         = ram_q;
    next_r.wr_prev = wr_s;
    next_r.rd_prev = rd_s;
    next_r.oe      = rd_s;
    next_r.hw_cols = HW_COLS_TBL[{col_b, col_a}];
    next_r.font_w  = FONT_W_TBL[{font_b, font_a}];
    if (r.busy != '0) begin
      next_r.busy = r.busy - 1'b1;
    end
    // Blink phase divider
    if (!r.disp_en[DM_BLINK]) begin
      next_r.blink     = 1'b1;
      next_r.blink_cnt = '0;
    end else if (r.blink_cnt == 32'(BLINK_CYC - 1)) begin
      next_r.blink     = ~r.blink;
      next_r.blink_cnt = '0;
    end else begin
      next_r.blink_cnt = r.blink_cnt + 32'h1;
    end
    // Host reads; a status read changes nothing else
    if (rd_lead) begin
      next_r.dout = cd_s ? status : r.stack;
    end
    if (r.auto_mode == AUTO_RD && !rd_s) begin
      next_r.stack = ram_q;
    end
    if (rd_trail && !cd_s && r.auto_mode == AUTO_RD) begin
      next_r.addr_ptr = ptr_inc;
    end
    // Host writes, taken at the end of the strobe
    if (wr_trail && ready) begin
      if (!cd_s) begin
        if (r.auto_mode == AUTO_WR) begin
          ram_we          = 1'b1;
          ram_wd          = wbyte;
          next_r.addr_ptr = ptr_inc;
        end else if (r.auto_mode == AUTO_OFF) begin
          if (r.dcnt == 2'h0) begin
            next_r.d1   = wbyte;
            next_r.dcnt = 2'h1;
          end else begin
            next_r.d2   = wbyte;
            next_r.dcnt = 2'h2;
          end
        end
      end else if (r.auto_mode != AUTO_OFF) begin
        if (wbyte[7:2] == OP_AUTO && wbyte[1]) begin
          next_r.auto_mode = AUTO_OFF;
          next_r.busy      = BUSY_W'(EXEC_CYC);
        end
      end else begin
        next_r.dcnt = 2'h0;
        next_r.busy = BUSY_W'(EXEC_CYC);
        next_r.err  = 1'b0;
        casez (wbyte)
          OP_CURSOR_SET: begin
            next_r.cursor_col = r.d1[6:0];
            next_r.cursor_row = r.d2[4:0];
          end
          OP_OFFSET_SET: begin
            next_r.glyph_offset = r.d1[4:0];
          end
          OP_ADDR_SET: begin
            next_r.addr_ptr = {r.d2, r.d1};
          end
          {OP_LAYOUT, 2'b??}: begin
            unique case (wbyte[1:0])
              LY_TEXT_BASE: next_r.text_base_addr = {r.d2, r.d1};
              LY_TEXT_COLS: next_r.text_col_count = r.d1;
              LY_GFX_BASE:  next_r.graphic_base_addr = {r.d2, r.d1};
              LY_GFX_COLS:  next_r.graphic_col_count = r.d1;
            endcase
          end
          {OP_MODE, 4'b????}: begin
            next_r.glyph_source_sel = wbyte[3];
            next_r.merge_mode       = wbyte[2:0];
          end
          {OP_DISP, 4'b????}: begin
            next_r.disp_en = wbyte[3:0];
          end
          {OP_CSHAPE, 3'b???}: begin
            next_r.cursor_lines = wbyte[2:0];
          end
          {OP_AUTO, 2'b??}: begin
            next_r.auto_mode = wbyte[1] ? AUTO_OFF
                             : (wbyte[0] ? AUTO_RD : AUTO_WR);
          end
          {OP_ACCESS, 3'b???}: begin
            if (wbyte[0]) begin
              next_r.stack = ram_q;
            end else begin
              ram_we = 1'b1;
              ram_wd = last_data;
            end
            if (!wbyte[2]) begin
              next_r.addr_ptr = wbyte[1] ? ptr_dec : ptr_inc;
            end
          end
          OP_PEEK: begin
            if (in_gfx) begin
              next_r.stack = ram_q;
            end else begin
              next_r.err = 1'b1;
            end
          end
          OP_COPY: begin
            if (!in_gfx) begin
              next_r.err = 1'b1;
            end else if (!DUAL_SCREEN && r.merge_mode != MERGE_TEXT_ATTR
                         && r.graphic_col_count != 8'h00) begin
              next_r.fsm      = FSM_COPY;
              next_r.copy_idx = 8'h00;
            end
          end
          {OP_BIT, 4'b????}: begin
            ram_we = 1'b1;
            ram_wd = ram_q;
            ram_wd[wbyte[2:0]] = wbyte[3];
          end
          default: begin
          end
        endcase
      end
    end
    // Line copy rewrites the displayed graphic bytes in place
    if (r.fsm == FSM_COPY) begin
      ram_we = 1'b1;
      ram_wa = rd_addr[ADDR_W-1:0];
      ram_wd = ram_q;
      next_r.copy_idx = r.copy_idx + 8'h01;
      if (r.copy_idx == r.graphic_col_count - 8'h01) begin
        next_r.fsm = FSM_IDLE;
      end
    end
    // Controller reset pin
    if (!rstn_s) begin
      next_r         = '0;
      next_r.disp_en = DISP_EN_RST;
      next_r.blink   = BLINK_RST;
      next_r.wr_prev = wr_s;
      next_r.rd_prev = rd_s;
      next_r.oe      = rd_s;
      next_r.dout    = rd_lead ? (cd_s ? status : 8'h00) : r.dout;
      ram_we         = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r         <= '0;
      r.disp_en <= DISP_EN_RST;
      r.blink   <= BLINK_RST;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign data_out          = r.dout;
  assign data_oe           = r.oe;
  assign addr_ptr          = r.addr_ptr;
  assign cursor_col        = r.cursor_col;
  assign cursor_row        = r.cursor_row;
  assign glyph_offset      = r.glyph_offset;
  assign text_base_addr    = r.text_base_addr;
  assign text_col_count    = r.text_col_count;
  assign graphic_base_addr = r.graphic_base_addr;
  assign graphic_col_count = r.graphic_col_count;
  assign glyph_source_sel  = r.glyph_source_sel;
  assign merge_mode        = r.merge_mode;
  assign display_enable    = r.disp_en;
  assign cursor_height     = {1'b0, r.cursor_lines} + 4'h1;
  assign blink_phase       = r.blink;
  assign hw_col_count      = r.hw_cols;
  assign font_width        = r.font_w;

  // Checks
  logic cmd_go;
  assign cmd_go = wr_trail && ready && cd_s && r.auto_mode == AUTO_OFF
                  && rstn_s;

  chk_status_drive: assert property (@(posedge clk) disable iff (rst)
    rd_lead && cd_s |=> data_out == $past(status) && data_oe)
    else $error("status byte not driven on status read");
  chk_busy_flags: assert property (@(posedge clk) disable iff (rst)
    cmd_go |=> !status[ST_CMD_OK] && !status[ST_DATA_OK])
    else $error("ready flags not dropped after a command");
  chk_blink_steady: assert property (@(posedge clk) disable iff (rst)
    !r.disp_en[DM_BLINK] && rstn_s |=> blink_phase)
    else $error("blink phase not normal with blink off");
  chk_peek_error: assert property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte == OP_PEEK && !in_gfx |=> status[ST_ERR])
    else $error("error flag not set on peek outside graphics");
  chk_ptr_load: assert property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte == OP_ADDR_SET |=> addr_ptr == $past({r.d2, r.d1}))
    else $error("address pointer not loaded low then high");
  chk_cursor_load: assert property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte == OP_CURSOR_SET
    |=> cursor_col == $past(r.d1[6:0]) && cursor_row == $past(r.d2[4:0]))
    else $error("cursor not loaded from data bytes");
  chk_disp_mode: assert property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte[7:4] == OP_DISP |=> display_enable == $past(wbyte[3:0]))
    else $error("display enables not taken from command");
  chk_auto_step: assert property (@(posedge clk) disable iff (rst)
    wr_trail && ready && !cd_s && r.auto_mode == AUTO_WR && rstn_s
    |=> addr_ptr == $past(addr_ptr) + 16'h0001)
    else $error("pointer not advanced in auto write");
  chk_reset_dark: assert property (@(posedge clk)
    rst |=> display_enable == DISP_EN_RST)
    else $error("display enables not cleared by reset");
  chk_status_pure: assert property (@(posedge clk) disable iff (rst)
    rd_lead && cd_s && !wr_trail && r.fsm == FSM_IDLE && r.busy == '0
    && r.auto_mode == AUTO_OFF && rstn_s
    |=> $stable(addr_ptr) && $stable(r.err) && $stable(r.stack))
    else $error("status read changed controller state");

  cov_auto_write: cover property (@(posedge clk) disable iff (rst)
    r.auto_mode == AUTO_WR && ram_we);
  cov_peek_ok: cover property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte == OP_PEEK && in_gfx);
  cov_copy_done: cover property (@(posedge clk) disable iff (rst)
    r.fsm == FSM_COPY ##1 r.fsm == FSM_IDLE);
  cov_bit_set: cover property (@(posedge clk) disable iff (rst)
    cmd_go && wbyte[7:4] == OP_BIT && wbyte[3]);
endmodule // lcp_cmd_port

// ===== lcp_host.sv
/*
  Host processor model on the parallel bus of the display port.
  Assumes one caller at a time and a design answering within 20 clocks.
*/
module lcp_host (
  input  wire logic       clk,
  output logic            ce_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            cd,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       hoe;
  logic [7:0] hd;
  int         timeouts = 0;

  // Released bus shows the design's byte while it drives, else the inverse of the last byte
  assign data_in = hoe ? hd : data_oe ? data_out : ~hd;

  initial begin
    {ce_n, rd_n, wr_n, cd, hoe} = 5'b11110;
    hd = 8'h00;
  end

  // One strobe; a read answer is taken at a rising edge
  task automatic xfer(input logic w, input logic c, input logic [7:0] d,
                      output logic [7:0] v);
    int n;
    @(negedge clk);
    cd = c;
    hd = d;
    hoe = w;
    ce_n = 1'b0;
    {wr_n, rd_n} = {~w, w};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < (w ? 5 : 20) && (w || data_oe !== 1'b1));
    if (!w && data_oe !== 1'b1) timeouts++;
    v = data_out;
    @(negedge clk);
    {ce_n, rd_n, wr_n} = 3'b111;
    repeat (6) @(negedge clk);
    hoe = 1'b0;
  endtask

  // Poll status until every masked bit reads 1
  task automatic wait_st(input logic [7:0] m, output logic [7:0] s);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b1, 8'h00, s);
      n++;
    end while ((s & m) !== m && n < 200);
    if ((s & m) !== m) timeouts++;
  endtask

  // Data bytes then the command, each after a status check
  task automatic send(input logic [7:0] op, input int nd = 0,
                      input logic [7:0] d1 = 8'h00, d2 = 8'h00,
                      m = 8'h01);
    logic [7:0] s;
    for (int i = 0; i < nd; i++) begin
      wait_st(8'h03, s);
      xfer(1'b1, 1'b0, i ? d2 : d1, s);
    end
    wait_st(m, s);
    xfer(1'b1, 1'b1, op, s);
    xfer(1'b0, 1'b1, 8'h00, s);
  endtask
endmodule // lcp_host

// ===== lcp_pkg.sv
/*
  Shared constants of the display controller host command port: opcodes,
  status bit positions, strap tables, reset values and timing counts.
  Assumes a 100 MHz system clock and 8 Kbyte of display RAM.
*/
package lcp_pkg;

  // Display RAM
  localparam int RAM_BYTES = 8192;
  localparam int ADDR_W    = 13;

  // Status byte bit positions
  localparam int ST_CMD_OK   = 0;
  localparam int ST_DATA_OK  = 1;
  localparam int ST_AUTO_RD  = 2;
  localparam int ST_AUTO_WR  = 3;
  localparam int ST_OPERABLE = 5;
  localparam int ST_ERR      = 6;
  localparam int ST_BLINK    = 7;

  // Display enable bit positions
  localparam int DM_BLINK   = 0;
  localparam int DM_CURSOR  = 1;
  localparam int DM_TEXT    = 2;
  localparam int DM_GRAPHIC = 3;

  // Command opcodes
  localparam logic [7:0] OP_CURSOR_SET = 8'h21;
  localparam logic [7:0] OP_OFFSET_SET = 8'h22;
  localparam logic [7:0] OP_ADDR_SET   = 8'h24;
  localparam logic [5:0] OP_LAYOUT     = 6'h10;
  localparam logic [3:0] OP_MODE       = 4'h8;
  localparam logic [3:0] OP_DISP       = 4'h9;
  localparam logic [4:0] OP_CSHAPE     = 5'h14;
  localparam logic [5:0] OP_AUTO       = 6'h2c;
  localparam logic [4:0] OP_ACCESS     = 5'h18;
  localparam logic [7:0] OP_PEEK       = 8'he0;
  localparam logic [7:0] OP_COPY       = 8'he8;
  localparam logic [3:0] OP_BIT        = 4'hf;

  // Layout selector and merge codes
  localparam logic [1:0] LY_TEXT_BASE = 2'h0;
  localparam logic [1:0] LY_TEXT_COLS = 2'h1;
  localparam logic [1:0] LY_GFX_BASE  = 2'h2;
  localparam logic [1:0] LY_GFX_COLS  = 2'h3;
  localparam logic [2:0] MERGE_TEXT_ATTR = 3'h4;

  // Reset values
  localparam logic [3:0] DISP_EN_RST = 4'h0;
  localparam logic       BLINK_RST   = 1'b1;

  // Strap tables, index {strap_b, strap_a}
  localparam logic [6:0] HW_COLS_TBL [4] = '{7'h50, 7'h40, 7'h28, 7'h20};
  localparam logic [3:0] FONT_W_TBL  [4] = '{4'h8, 4'h7, 4'h6, 4'h5};

  // Timing: command execution takes 32 oscillator periods
  localparam int CLK_PERIOD_NS  = 10;
  localparam int OSC_PERIOD_NS  = 100;
  localparam int EXEC_OSC_TICKS = 32;
  localparam int EXEC_NS        = EXEC_OSC_TICKS * OSC_PERIOD_NS;
  localparam int EXEC_CYC       = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W         = $clog2(EXEC_CYC + 1);

  // Blink half period
  localparam int BLINK_HALF_NS  = 500000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {AUTO_OFF, AUTO_WR, AUTO_RD} lcp_auto_t;
  typedef enum logic {FSM_IDLE, FSM_COPY} lcp_fsm_t;

endpackage

// ===== lcp_sync3.sv
/*
  Three flip-flop pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to clk; output changes only when the
  second and third stages agree.
*/
module lcp_sync3 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lcp_sync_t;

  lcp_sync_t r;
  lcp_sync_t next_r;

  initial begin
    if (W < 1) $error("lcp_sync3: W must be at least 1");
  end

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.q;
endmodule // lcp_sync3
